// file: hw/fpc_host.sv
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module fpc_host
   import fpc_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        reset_i,
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic [15:0]      reg_rdata_o,
   input  wire logic [15:0] dq_i,
   output logic [15:0]      dq_o,
   output logic             dq_oe_o,
   output logic [21:0]      a_o,
   output logic             ce_n_o,
   output logic             oe_n_o,
   output logic             we_n_o,
   output logic             reset_pin_n_o
);
   typedef enum logic [2:0] {
      FH_IDLE, FH_W1, FH_W2, FH_POLL, FH_READ, FH_SINGLE
   } fpc_state_t;
   typedef enum logic [1:0] {FO_NONE, FO_PROG, FO_ERASE} fpc_op_t;

   fpc_cyc_if cyc ();
   fpc_state_t  st_q, st_d;
   fpc_op_t     op_q, op_d;       // Running operation
   logic        esusp_q, esusp_d; // Erase held in suspend
   logic        psusp_q, psusp_d;
   logic        busy_q, busy_d;
   logic        sent_q, sent_d;
   logic        nested_q, nested_d;
   logic        susp_pend_q, susp_pend_d; // Suspend waiting for a poll gap
   logic [21:0] addr_q, addr_d;
   logic [15:0] data_q, data_d;
   logic [7:0]  sr_q, sr_d;
   logic [15:0] rdat_q, rdat_d;
   logic [2:0]  err_q, err_d;
   logic        rst_q, rst_d;
   logic [7:0]  c1_q, c1_d;
   logic [7:0]  c2_q, c2_d;
   logic        wr2_q, wr2_d;
   logic [15:0] rdo_q, rdo_d;
   logic        chk_ready, chk_fail;
   logic [2:0]  chk_code;
   logic        allowed;

   fpc_bus_cycle u_cyc (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .cyc       (cyc.slave),
      .dq_i      (dq_i),
      .ce_n_o    (ce_n_o),
      .oe_n_o    (oe_n_o),
      .we_n_o    (we_n_o),
      .a_o       (a_o),
      .dq_o      (dq_o),
      .dq_oe_o   (dq_oe_o)
   );
   fpc_status_chk u_chk (
      .sr_i    (cyc.rdata[7:0]),
      .erase_i (op_q == FO_ERASE),
      .ready_o (chk_ready),
      .fail_o  (chk_fail),
      .code_o  (chk_code)
   );

   // ==========================================================
   // Order gating by device state
   always_comb begin
      allowed = 1'b0;
      if (busy_q && op_q != FO_NONE)
         allowed = (reg_wdata_i[3:0] == OP_SUSPEND);
      else if (psusp_q)
         allowed = (reg_wdata_i[3:0] == OP_RESUME || reg_wdata_i[3:0] == OP_RD_STAT ||
                    reg_wdata_i[3:0] == OP_RD_ARRAY || reg_wdata_i[3:0] == OP_READ);
      else if (esusp_q)
         allowed = (reg_wdata_i[3:0] != OP_ERASE && reg_wdata_i[3:0] != OP_SUSPEND &&
                    reg_wdata_i[3:0] != OP_CLEAR);
      else
         allowed = (reg_wdata_i[3:0] != OP_SUSPEND && reg_wdata_i[3:0] != OP_RESUME);
      if (!rst_q) allowed = 1'b0;
   end

   always_comb begin
      st_d = st_q; op_d = op_q; esusp_d = esusp_q; psusp_d = psusp_q;
      busy_d = busy_q; sent_d = 1'b0; nested_d = nested_q; susp_pend_d = susp_pend_q;
      addr_d = addr_q; data_d = data_q; sr_d = sr_q; rdat_d = rdat_q;
      err_d = err_q; rst_d = rst_q; c1_d = c1_q; c2_d = c2_q; wr2_d = wr2_q;
      rdo_d = 16'h0000;
      if (reg_wr_i) begin
         case (reg_addr_i)
            REG_ADDR_LO: addr_d[15:0] = reg_wdata_i;
            REG_ADDR_HI: addr_d[21:16] = reg_wdata_i[5:0];
            REG_DATA:    data_d = reg_wdata_i;
            REG_CTRL: begin
               rst_d = reg_wdata_i[0];
               if (!reg_wdata_i[0]) begin
                  st_d = FH_IDLE; op_d = FO_NONE; busy_d = 1'b0;
                  esusp_d = 1'b0; psusp_d = 1'b0; nested_d = 1'b0;
                  susp_pend_d = 1'b0;
               end
            end
            // Busy polls never idle, so suspend is queued for the next poll gap
            REG_CMD: if (st_q == FH_POLL && busy_q && allowed &&
                         reg_wdata_i[3:0] == OP_SUSPEND) begin
               susp_pend_d = 1'b1;
            end else if (st_q == FH_IDLE && allowed) begin
               case (reg_wdata_i[3:0])
                  OP_PROGRAM: begin
                     c1_d = CMD_PROG_SETUP; c2_d = data_q[7:0]; wr2_d = 1'b1;
                     nested_d = esusp_q;
                     op_d = FO_PROG; st_d = FH_W1; err_d = 3'h0;
                  end
                  OP_ERASE: begin
                     c1_d = CMD_ERASE_SETUP; c2_d = CMD_CONFIRM; wr2_d = 1'b1;
                     op_d = FO_ERASE; st_d = FH_W1; err_d = 3'h0;
                  end
                  OP_SUSPEND: begin c1_d = CMD_SUSPEND; wr2_d = 1'b0; st_d = FH_W1; end
                  OP_RESUME: begin
                     c1_d = CMD_CONFIRM; wr2_d = 1'b0; st_d = FH_W1;
                     if (psusp_q) begin psusp_d = 1'b0; op_d = FO_PROG; end
                     else begin esusp_d = 1'b0; op_d = FO_ERASE; end
                  end
                  OP_CLEAR:    begin c1_d = CMD_CLEAR_STATUS; wr2_d = 1'b0; st_d = FH_W1; end
                  OP_RD_STAT:  begin c1_d = CMD_READ_STATUS; wr2_d = 1'b0; st_d = FH_W1; end
                  OP_RD_ARRAY: begin c1_d = CMD_READ_ARRAY; wr2_d = 1'b0; st_d = FH_W1; end
                  OP_READ:     st_d = FH_READ;
                  default: ;
               endcase
            end
            default: ;
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            REG_ADDR_LO: rdo_d = addr_q[15:0];
            REG_ADDR_HI: rdo_d = {10'h000, addr_q[21:16]};
            REG_DATA:    rdo_d = data_q;
            REG_STATUS:  rdo_d = {err_q, nested_q, psusp_q, esusp_q, busy_q,
                                  st_q != FH_IDLE, sr_q};
            REG_RDATA:   rdo_d = rdat_q;
            REG_CTRL:    rdo_d = {15'h0000, rst_q};
            default:     rdo_d = 16'h0000;
         endcase
      end
      case (st_q)
         FH_IDLE: ;
         FH_W1: if (!sent_q) sent_d = 1'b1;
            else if (cyc.done) begin
               if (wr2_q) st_d = FH_W2;
               else if (c1_q == CMD_SUSPEND || c1_q == CMD_CONFIRM) begin
                  st_d = FH_POLL;
                  if (c1_q == CMD_CONFIRM) busy_d = 1'b1;
               end
               else st_d = FH_IDLE;
            end else sent_d = 1'b1;
         FH_W2: if (!sent_q) sent_d = 1'b1;
            else if (cyc.done) begin
               busy_d = 1'b1; st_d = FH_POLL;
            end else sent_d = 1'b1;
         FH_POLL: if (!sent_q) sent_d = 1'b1;
            else if (cyc.done) begin
               sr_d = cyc.rdata[7:0];
               if (chk_ready) begin
                  busy_d = 1'b0; st_d = FH_IDLE;
                  if (cyc.rdata[SB_ESUSP] && c1_q == CMD_SUSPEND) esusp_d = 1'b1;
                  else if (cyc.rdata[SB_PSUSP] && c1_q == CMD_SUSPEND) psusp_d = 1'b1;
                  else begin
                     err_d = chk_code;
                     if (op_q == FO_PROG && nested_q) begin op_d = FO_ERASE; nested_d = 1'b0; end
                     else op_d = FO_NONE;
                  end
                  susp_pend_d = 1'b0;
               end else if (susp_pend_q) begin
                  st_d = FH_W1; c1_d = CMD_SUSPEND; wr2_d = 1'b0; susp_pend_d = 1'b0;
               end
            end else sent_d = 1'b1;
         FH_READ: if (!sent_q) sent_d = 1'b1;
            else if (cyc.done) begin rdat_d = cyc.rdata; st_d = FH_IDLE; end
            else sent_d = 1'b1;
         default: st_d = FH_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         st_q <= FH_IDLE; op_q <= FO_NONE; esusp_q <= 1'b0; psusp_q <= 1'b0;
         busy_q <= 1'b0; sent_q <= 1'b0; nested_q <= 1'b0; susp_pend_q <= 1'b0;
         addr_q <= 22'h000000; data_q <= 16'h0000; sr_q <= 8'h80;
         rdat_q <= 16'h0000; err_q <= 3'h0; rst_q <= 1'b0;
         c1_q <= 8'h00; c2_q <= 8'h00; wr2_q <= 1'b0; rdo_q <= 16'h0000;
      end else begin
         st_q <= st_d; op_q <= op_d; esusp_q <= esusp_d; psusp_q <= psusp_d;
         busy_q <= busy_d; sent_q <= sent_d; nested_q <= nested_d; susp_pend_q <= susp_pend_d;
         addr_q <= addr_d; data_q <= data_d; sr_q <= sr_d;
         rdat_q <= rdat_d; err_q <= err_d; rst_q <= rst_d;
         c1_q <= c1_d; c2_q <= c2_d; wr2_q <= wr2_d; rdo_q <= rdo_d;
      end
   end

   // Start pulse in the first cycle of each bus phase
   assign cyc.start    = (st_q != FH_IDLE) && !sent_q;
   assign cyc.is_write = (st_q == FH_W1 || st_q == FH_W2);
   assign cyc.addr     = addr_q;
   assign cyc.wdata    = (st_q == FH_W2) ? ((c1_q == CMD_PROG_SETUP) ? data_q
                                            : {8'h00, c2_q})
                                         : {8'h00, c1_q};
   assign reg_rdata_o   = rdo_q;
   // Pin held low until software releases it; low aborts device work
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) reset_pin_n_o <= 1'b0;
      else reset_pin_n_o <= rst_d;
   end

   // ==========================================================
   // Checks
   property p_busy_suspend_only;
      @(posedge ref_clk_i) disable iff (reset_i)
         (st_q == FH_W1 && cyc.start && busy_q) |-> (c1_q == CMD_SUSPEND);
   endproperty
   a_busy_suspend_only: assert property (p_busy_suspend_only) else $error("bad cmd while busy");
   property p_erase_pair;
      @(posedge ref_clk_i) disable iff (reset_i)
         (st_q == FH_W2 && cyc.start && op_q == FO_ERASE) |-> (c1_q == CMD_ERASE_SETUP && c2_q == CMD_CONFIRM);
   endproperty
   a_erase_pair: assert property (p_erase_pair) else $error("erase not setup+confirm");
   property p_poll_after_op;
      @(posedge ref_clk_i) disable iff (reset_i)
         (st_q == FH_W2 && cyc.done) |=> (st_q == FH_POLL && busy_q);
   endproperty
   a_poll_after_op: assert property (p_poll_after_op) else $error("no poll after op");
   property p_ready_ends;
      @(posedge ref_clk_i) disable iff (reset_i)
         (st_q == FH_POLL && cyc.done && !cyc.rdata[SB_READY] && rst_q)
         |=> (st_q == FH_POLL || (st_q == FH_W1 && c1_q == CMD_SUSPEND));
   endproperty
   a_ready_ends: assert property (p_ready_ends) else $error("left poll while busy");
   property p_esusp_hold;
      @(posedge ref_clk_i) disable iff (reset_i)
         (esusp_q && !(reg_wr_i && reg_addr_i == REG_CMD) && !(reg_wr_i && reg_addr_i == REG_CTRL))
         |=> esusp_q;
   endproperty
   a_esusp_hold: assert property (p_esusp_hold) else $error("erase suspend lost");
   property p_psusp_hold;
      @(posedge ref_clk_i) disable iff (reset_i)
         (psusp_q && !(reg_wr_i && reg_addr_i == REG_CMD) && !(reg_wr_i && reg_addr_i == REG_CTRL))
         |=> psusp_q;
   endproperty
   a_psusp_hold: assert property (p_psusp_hold) else $error("program suspend lost");
   property p_reset_abort;
      @(posedge ref_clk_i) disable iff (reset_i)
         (reg_wr_i && reg_addr_i == REG_CTRL && !reg_wdata_i[0]) |=> (!reset_pin_n_o && !busy_q);
   endproperty
   a_reset_abort: assert property (p_reset_abort) else $error("reset not aborting");
   property p_rdata_next;
      @(posedge ref_clk_i) disable iff (reset_i)
         (reg_rd_i && reg_addr_i == REG_ADDR_LO) |=> (reg_rdata_o == $past(addr_q));
   endproperty
   a_rdata_next: assert property (p_rdata_next) else $error("read data late");
   c_prog: cover property (@(posedge ref_clk_i) st_q == FH_W2 && op_q == FO_PROG);
   c_erase: cover property (@(posedge ref_clk_i) st_q == FH_W2 && op_q == FO_ERASE);
   c_esusp: cover property (@(posedge ref_clk_i) esusp_q && st_q == FH_W2);
   c_fail: cover property (@(posedge ref_clk_i) err_q != 3'h0);
endmodule : fpc_host
`default_nettype wire

// file: hw/fpc_pkg.sv
package fpc_pkg;
   // ==========================================================
   // Command codes
   localparam logic [7:0] CMD_PROG_SETUP     = 8'h40;
   localparam logic [7:0] CMD_ALT_PROG_SETUP = 8'h10;
   localparam logic [7:0] CMD_ERASE_SETUP    = 8'h20;
   localparam logic [7:0] CMD_CONFIRM        = 8'hD0;
   localparam logic [7:0] CMD_SUSPEND        = 8'hB0;
   localparam logic [7:0] CMD_CLEAR_STATUS   = 8'h50;
   localparam logic [7:0] CMD_READ_STATUS    = 8'h70;
   localparam logic [7:0] CMD_READ_ARRAY     = 8'hFF;
   // ==========================================================
   // Sequencer status bit positions
   localparam int SB_READY   = 7;
   localparam int SB_ESUSP   = 6;
   localparam int SB_EERR    = 5;
   localparam int SB_PERR    = 4;
   localparam int SB_VLOW    = 3;
   localparam int SB_PSUSP   = 2;
   localparam int SB_LOCKV   = 1;
   // ==========================================================
   // Own register map (word index = address)
   localparam logic [3:0] REG_ADDR_LO = 4'h0;
   localparam logic [3:0] REG_ADDR_HI = 4'h1;
   localparam logic [3:0] REG_DATA    = 4'h2;
   localparam logic [3:0] REG_CMD     = 4'h3;
   localparam logic [3:0] REG_STATUS  = 4'h4;
   localparam logic [3:0] REG_RDATA   = 4'h5;
   localparam logic [3:0] REG_CTRL    = 4'h6;
   // Orders written to REG_CMD
   localparam logic [3:0] OP_PROGRAM  = 4'h1;
   localparam logic [3:0] OP_ERASE    = 4'h2;
   localparam logic [3:0] OP_SUSPEND  = 4'h3;
   localparam logic [3:0] OP_RESUME   = 4'h4;
   localparam logic [3:0] OP_CLEAR    = 4'h5;
   localparam logic [3:0] OP_RD_STAT  = 4'h6;
   localparam logic [3:0] OP_RD_ARRAY = 4'h7;
   localparam logic [3:0] OP_READ     = 4'h8;
   // ==========================================================
   // Bus timing (ns) and derived cycles at 100 MHz
   localparam int CLK_NS      = 10;
   localparam int T_PULSE_NS  = 70;
   localparam int T_ACCESS_NS = 80;
   localparam int T_PULSE_CYC  = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_ACCESS_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int POLL_GAP_CYC = 2;
endpackage : fpc_pkg

// file: hw/fpc_cyc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fpc_cyc_if;
   logic        start;
   logic        is_write;
   logic [21:0] addr;
   logic [15:0] wdata;
   logic        done;
   logic [15:0] rdata;
   modport master (output start, output is_write, output addr, output wdata,
                   input done, input rdata);
   modport slave  (input start, input is_write, input addr, input wdata,
                   output done, output rdata);
endinterface : fpc_cyc_if
`default_nettype wire

// file: hw/fpc_bus_cycle.sv
`timescale 1ns/10ps
`default_nettype none
// One asynchronous flash bus cycle: write or read with strobe pulse width.
module fpc_bus_cycle
   import fpc_pkg::*;
(
   input  wire logic    ref_clk_i,
   input  wire logic    reset_i,
   fpc_cyc_if.slave     cyc,
   input  wire logic [15:0] dq_i,
   output logic         ce_n_o,
   output logic         oe_n_o,
   output logic         we_n_o,
   output logic [21:0]  a_o,
   output logic [15:0]  dq_o,
   output logic         dq_oe_o
);
   typedef enum logic [1:0] {FBC_IDLE, FBC_ACT, FBC_GAP} fpc_bc_st_t;
   fpc_bc_st_t  st_q, st_d;
   logic [3:0]  cnt_q, cnt_d;
   logic        wr_q, wr_d;
   logic        done_q, done_d;
   logic [15:0] rd_q, rd_d;
   logic [21:0] a_q, a_d;
   logic [15:0] wd_q, wd_d;

   always_comb begin
      st_d = st_q; cnt_d = cnt_q; wr_d = wr_q; done_d = 1'b0;
      rd_d = rd_q; a_d = a_q; wd_d = wd_q;
      case (st_q)
         FBC_IDLE: if (cyc.start) begin
            st_d = FBC_ACT; wr_d = cyc.is_write; a_d = cyc.addr; wd_d = cyc.wdata;
            cnt_d = cyc.is_write ? 4'(T_PULSE_CYC) : 4'(T_ACCESS_CYC);
         end
         FBC_ACT: if (cnt_q == 4'h1) begin
            // Strobe high gives a fresh edge for the next status poll
            if (!wr_q) rd_d = dq_i;
            st_d = FBC_GAP; cnt_d = 4'(POLL_GAP_CYC);
         end else cnt_d = cnt_q - 4'h1;
         FBC_GAP: if (cnt_q == 4'h1) begin
            st_d = FBC_IDLE; done_d = 1'b1;
         end else cnt_d = cnt_q - 4'h1;
         default: st_d = FBC_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         st_q <= FBC_IDLE; cnt_q <= 4'h0; wr_q <= 1'b0; done_q <= 1'b0;
         rd_q <= 16'h0000; a_q <= 22'h000000; wd_q <= 16'h0000;
      end else begin
         st_q <= st_d; cnt_q <= cnt_d; wr_q <= wr_d; done_q <= done_d;
         rd_q <= rd_d; a_q <= a_d; wd_q <= wd_d;
      end
   end

   // Strobes registered; write is CE low, OE high, WE low
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         ce_n_o <= 1'b1; oe_n_o <= 1'b1; we_n_o <= 1'b1; dq_oe_o <= 1'b0;
         a_o <= 22'h000000; dq_o <= 16'h0000;
      end else begin
         ce_n_o  <= !(st_d == FBC_ACT);
         oe_n_o  <= !(st_d == FBC_ACT && !wr_d);
         we_n_o  <= !(st_d == FBC_ACT && wr_d);
         dq_oe_o <= (st_d == FBC_ACT && wr_d);
         a_o     <= a_d;
         dq_o    <= wd_d;
      end
   end
   assign cyc.done  = done_q;
   assign cyc.rdata = rd_q;

   // ==========================================================
   // Checks
   property p_no_contention;
      @(posedge ref_clk_i) disable iff (reset_i) dq_oe_o |-> (oe_n_o && !we_n_o && !ce_n_o);
   endproperty
   a_no_contention: assert property (p_no_contention) else $error("dq driven outside write");
   property p_strobe_excl;
      @(posedge ref_clk_i) disable iff (reset_i) !(!oe_n_o && !we_n_o);
   endproperty
   a_strobe_excl: assert property (p_strobe_excl) else $error("oe and we both low");
endmodule : fpc_bus_cycle
`default_nettype wire

// file: hw/fpc_status_chk.sv
`timescale 1ns/10ps
`default_nettype none
// Decodes a sequencer status byte into the host's verdict.
module fpc_status_chk
   import fpc_pkg::*;
(
   input  wire logic [7:0] sr_i,
   input  wire logic       erase_i,
   output logic            ready_o,
   output logic            fail_o,
   output logic [2:0]      code_o
);
   always_comb begin
      ready_o = sr_i[SB_READY];
      code_o  = 3'h0;
      // Error bits only trusted once the sequencer is ready
      if (sr_i[SB_READY]) begin
         if (sr_i[SB_LOCKV])                          code_o = 3'h1;
         else if (sr_i[SB_VLOW])                      code_o = 3'h2;
         else if (sr_i[SB_PERR] && sr_i[SB_EERR])     code_o = 3'h3;
         else if (erase_i && sr_i[SB_EERR])           code_o = 3'h4;
         else if (!erase_i && sr_i[SB_PERR])          code_o = 3'h5;
      end
      fail_o = (code_o != 3'h0);
   end
endmodule : fpc_status_chk
`default_nettype wire

// file: test/fpc_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Flash bank model, one word of array storage
module fpc_flash_model
   import fpc_pkg::*;
#(
   parameter int BUSY_CYC = 150
)(
   input  wire logic        ref_clk_i,
   input  wire logic        ce_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic        rp_n_i,
   input  wire logic [21:0] a_i,
   input  wire logic [15:0] dq_i,
   output logic [15:0]      dq_o
);
   logic [21:0] wa = '0, pa = '0, maddr = '0;
   logic [15:0] wd = '0, pd = '0, mem = '0, last = '0;
   logic [6:0]  sr = '0;
   logic [1:0]  pend = '0, op = '0;
   logic        stat_md = 1'b0, we_q = 1'b1, susp = 1'b0;
   int          cnt = 0;
   wire         rd_on = !ce_n_i && !oe_n_i && we_n_i && rp_n_i;
   // Released bus shows the inverse, never a held value
   assign dq_o = rd_on ? last : ~last;
   always @(posedge ref_clk_i) begin
      we_q <= we_n_i;
      if (!ce_n_i && !we_n_i) begin
         wa <= a_i;
         wd <= dq_i;
      end
      if (rd_on) last <= stat_md ? {8'h00, cnt == 0 || susp, sr} :
                         (a_i == maddr ? mem : 16'h0000);
      if (cnt != 0 && !susp) begin
         cnt <= cnt - 1;
         if (cnt == 1 && op == 2'd1) begin
            mem <= pd;
            maddr <= pa;
         end else if (cnt == 1 && pa[21:15] == maddr[21:15]) mem <= 16'hFFFF;
      end
      if (!rp_n_i) begin
         cnt <= 0;
         susp <= 1'b0;
         pend <= 2'd0;
         stat_md <= 1'b0;
         sr <= '0;
      end else if (we_n_i && !we_q) begin
         if (pend != 2'd0) begin
            if (pend == 2'd1 || wd[7:0] == CMD_CONFIRM) begin
               // Block top address bit marks the locked half
               if (wa[21]) sr[1] <= 1'b1;
               else begin
                  op <= pend;
                  cnt <= BUSY_CYC;
                  pa <= wa;
                  pd <= wd;
               end
            end
            pend <= 2'd0;
            stat_md <= 1'b1;
         end else if (cnt != 0 && !susp) begin
            if (wd[7:0] == CMD_SUSPEND) begin
               susp <= 1'b1;
               sr[op == 2'd2 ? 6 : 2] <= 1'b1;
            end
         end else if (wd[7:0] == CMD_CONFIRM) begin
            susp <= 1'b0;
            sr[6] <= 1'b0;
            sr[2] <= 1'b0;
         end else if (wd[7:0] == CMD_READ_ARRAY || wd[7:0] == CMD_READ_STATUS) begin
            stat_md <= wd[7:0] == CMD_READ_STATUS;
         end else if (cnt == 0) begin
            if (wd[7:0] == CMD_CLEAR_STATUS) begin
               sr[5:3] <= 3'b000;
               sr[1] <= 1'b0;
            end
            if (wd[7:0] == CMD_ERASE_SETUP) pend <= 2'd2;
            if (wd[7:0] == CMD_PROG_SETUP || wd[7:0] == CMD_ALT_PROG_SETUP) pend <= 2'd1;
         end
      end
   end
endmodule // fpc_flash_model
`default_nettype wire

// file: test/fpc_host_tb.sv
`timescale 1ns/10ps
`default_nettype none
module fpc_host_tb
   import fpc_pkg::*;
;
   logic        ref_clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdat = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   wire  [15:0] rdat, dq_in, dq_out;
   wire  [21:0] fa;
   wire         ce_n, oe_n, we_n, rp_n;
   int          fails = 0;
   int          check_count = 0;
   int          cyc = 0;
   logic [15:0] s;
   fpc_host dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(addr),
      .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
      .dq_i(dq_in), .dq_o(dq_out), .dq_oe_o(), .a_o(fa), .ce_n_o(ce_n),
      .oe_n_o(oe_n), .we_n_o(we_n), .reset_pin_n_o(rp_n));
   fpc_flash_model flash (.ref_clk_i(ref_clk_i), .ce_n_i(ce_n), .oe_n_i(oe_n),
      .we_n_i(we_n), .rp_n_i(rp_n), .a_i(fa), .dq_i(dq_out), .dq_o(dq_in));
   initial forever #5 ref_clk_i = ~ref_clk_i;
   // ==========================================================
   // Register access and checking
   task automatic conclude();
      if (fails == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk_i);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge ref_clk_i);
      wr <= 1'b0;
   endtask
   task automatic rdr(input logic [3:0] a);
      @(posedge ref_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk_i);
      rd <= 1'b0;
      #1 s = rdat;
   endtask
   task automatic op(input logic [3:0] o);
      wrr(REG_CMD, {12'h000, o});
   endtask
   // Engine needs a few edges before busy shows
   task automatic idle();
      int n;
      n = 0;
      repeat (4) @(posedge ref_clk_i);
      do begin rdr(REG_STATUS); n++; end while (s[9:8] !== 2'b00 && n < 400);
   endtask
   // Suspend is dropped until the engine shows busy, so retry
   task automatic halt(input int b);
      int n;
      n = 0;
      do begin op(OP_SUSPEND); rdr(REG_STATUS); n++; end while (s[b] !== 1'b1 && n < 100);
      idle();
   endtask
   task automatic rdarr();
      op(OP_RD_ARRAY);
      idle();
      op(OP_READ);
      idle();
      rdr(REG_RDATA);
   endtask
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fails++;
         conclude();
      end
   end
   // ==========================================================
   // Scenarios
   initial begin
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      #1 chk({15'h0000, rp_n}, 16'h0000);
      wrr(REG_CTRL, 16'h0001);
      wrr(REG_ADDR_LO, 16'h0010);
      wrr(REG_ADDR_HI, 16'h0000);
      wrr(REG_DATA, 16'hA5C3);
      op(OP_PROGRAM);
      idle();
      chk(s, 16'h0080);
      rdarr();
      chk(s, 16'hA5C3);
      wrr(REG_ADDR_LO, 16'h7FFF);
      op(OP_ERASE);
      idle();
      chk(s, 16'h0080);
      wrr(REG_ADDR_LO, 16'h0010);
      rdarr();
      chk(s, 16'hFFFF);
      op(OP_PROGRAM);
      halt(11);
      chk({s[15:10], 2'b00, s[7:0]}, 16'h0884);
      op(OP_RESUME);
      idle();
      chk(s, 16'h0080);
      op(OP_ERASE);
      halt(10);
      chk({s[15:10], 2'b00, s[7:0]}, 16'h04C0);
      op(OP_RESUME);
      idle();
      chk(s, 16'h0080);
      wrr(REG_ADDR_HI, 16'h0020);
      op(OP_PROGRAM);
      idle();
      chk(s, 16'h2082);
      op(OP_CLEAR);
      idle();
      wrr(REG_ADDR_HI, 16'h0000);
      op(OP_PROGRAM);
      idle();
      chk(s, 16'h0080);
      wrr(REG_DATA, 16'h1234);
      op(OP_PROGRAM);
      repeat (40) @(posedge ref_clk_i);
      wrr(REG_CTRL, 16'h0000);
      @(posedge ref_clk_i);
      #1 chk({15'h0000, rp_n}, 16'h0000);
      rdr(REG_STATUS);
      chk({8'h00, s[15:8]}, 16'h0000);
      // Let the cut flash cycle drain before new orders
      repeat (12) @(posedge ref_clk_i);
      wrr(REG_CTRL, 16'h0001);
      rdarr();
      chk(s, 16'hA5C3);
      conclude();
   end
endmodule // fpc_host_tb
`default_nettype wire
